// ==== dscs_pkg.sv ====
// Constants, register map and state type of the double speed clock select
package dscs_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] DSCS_IDX_SPEED_MAIN   = 8'h8f;
    localparam logic [7:0] DSCS_IDX_SPEED_SERIAL = 8'h9f;
    localparam logic [7:0] DSCS_IDX_STATUS       = 8'h20;
    localparam int         DSCS_ADR_W            = 10;
    localparam int         DSCS_IDX_LSB          = 2;

    localparam logic [7:0] DSCS_RST_SPEED_MAIN   = 8'h00;
    localparam logic       DSCS_RST_SPEED_SERIAL = 1'b0;

    // Field positions of the main and serial speed select registers
    localparam int DSCS_BIT_CPU       = 0;
    localparam int DSCS_BIT_PERIPH_LO = 1;
    localparam int DSCS_BIT_PERIPH_HI = 7;
    localparam int DSCS_BIT_SPI       = 0;

    // Status register fields
    localparam int DSCS_ST_CPU_ACTIVE = 0;
    localparam int DSCS_ST_BOOT_DONE  = 1;

    // Peripheral enable order: timer0, timer1, timer2, serial, counter array, watchdog, CAN, SPI
    localparam int DSCS_NUM_PERIPH = 8;

    // Oscillator periods per cycle; one clk period is one oscillator period
    localparam int DSCS_PERIODS_STD  = 12;
    localparam int DSCS_PERIODS_FAST = 6;
    localparam logic [3:0] DSCS_PHASE_LAST = 4'(DSCS_PERIODS_STD - 1);
    localparam logic [3:0] DSCS_PHASE_MID  = 4'(DSCS_PERIODS_FAST - 1);
    localparam logic [3:0] DSCS_PHASE_ZERO = 4'h0;
    localparam logic [3:0] DSCS_PHASE_ONE  = 4'h1;

    // Edges after reset release before the synchronised boot option is valid
    localparam logic [1:0] DSCS_BOOT_WAIT = 2'h2;

    typedef struct packed {
        logic [7:0]                 speed_main;
        logic                       speed_spi;
        logic                       cpu_fast;
        logic [DSCS_NUM_PERIPH-1:0] periph_sel;
        logic [3:0]                 phase;
        logic                       boot_s1;
        logic                       boot_s2;
        logic [1:0]                 boot_cnt;
        logic                       boot_done;
        logic                       ack;
        logic [7:0]                 rdata;
        logic                       core_en;
        logic                       mcycle_en;
        logic [DSCS_NUM_PERIPH-1:0] periph_en;
    } dscs_state_t;

endpackage

// ==== dscs_rate_en.sv ====
// Cycle enable for one clock consumer: a pulse every 6 or 12 oscillator periods
`timescale 1ns/1ps
module dscs_rate_en
    import dscs_pkg::*;
(
    input  wire logic [3:0] phase,
    input  wire logic       fast,
    output logic            en
);
    import dscs_pkg::*;

    // Both rates end on the shared phase count, so a rate change never cuts a cycle short
    always_comb begin
        if (fast) begin
            en = (phase == DSCS_PHASE_MID) || (phase == DSCS_PHASE_LAST);
        end else begin
            en = (phase == DSCS_PHASE_LAST);
        end
    end
endmodule

// ==== dscs_clock_select.sv ====
// Double speed clock select: divider, mode switch, peripheral enables, Wishbone registers
//
// How it works
// - Double speed runs the core at six oscillator periods per machine cycle, not twelve.
// - A divide-by-two sits before the core phase generator; software may bypass it.
// - One CPU select bit switches core between twelve and six periods, both ways.
// - Reset returns to standard speed with divider active unless boot option programmed.
// - Setting the CPU select bit also speeds each peripheral whose own select bit is clear.
// - Timers, serial, counter array, watchdog, CAN go fast only with own bit clear.
// - CPU select change takes effect only at a rising edge of the divided clock.
// - Programmed boot option starts the device in double speed right after reset.
// - Peripheral select bits act only while the CPU select bit is set.
// - Clear peripheral bit gives six periods per peripheral cycle, set gives twelve.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module dscs_clock_select
    import dscs_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    boot_double_speed_option,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [DSCS_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         core_phase_en,
    output logic                         machine_cycle_en,
    output logic                         cpu_double_speed_active,
    output logic                         timer_zero_en,
    output logic                         timer_one_en,
    output logic                         timer_two_en,
    output logic                         serial_port_en,
    output logic                         counter_array_en,
    output logic                         watchdog_en,
    output logic                         can_en,
    output logic                         serial_peripheral_en
);
    import dscs_pkg::*;

    dscs_state_t                 cur_ff;
    dscs_state_t                 nxt_state;
    logic [DSCS_NUM_PERIPH:0]    fast_vec;
    logic [DSCS_NUM_PERIPH:0]    pulse_vec;
    logic [DSCS_NUM_PERIPH-1:0]  periph_sel_now;
    logic                        div2_rise;
    logic                        req;
    logic [7:0]                  idx;

    function automatic logic [3:0] dscs_phase_next(input logic [3:0] ph);
        dscs_phase_next = (ph == DSCS_PHASE_LAST) ? DSCS_PHASE_ZERO : ph + DSCS_PHASE_ONE;
    endfunction

    assign idx            = wb_adr_i[DSCS_ADR_W-1:DSCS_IDX_LSB];
    assign req            = wb_cyc_i && wb_stb_i && !cur_ff.ack && cur_ff.boot_done;
    assign periph_sel_now = {cur_ff.speed_spi,
                             cur_ff.speed_main[DSCS_BIT_PERIPH_HI:DSCS_BIT_PERIPH_LO]};
    // Divided clock rises when the phase count moves from even to odd
    assign div2_rise      = !cur_ff.phase[0];

    // Slot 0 is the core machine cycle; slots 1.. are the peripherals
    always_comb begin
        fast_vec[0] = cur_ff.cpu_fast;
        for (int i = 0; i < DSCS_NUM_PERIPH; i++) begin
            fast_vec[i+1] = cur_ff.cpu_fast && !cur_ff.periph_sel[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g <= DSCS_NUM_PERIPH; g++) begin : g_rate
            dscs_rate_en u_rate (
                .phase (cur_ff.phase),
                .fast  (fast_vec[g]),
                .en    (pulse_vec[g])
            );
        end
    endgenerate

    always_comb begin
        nxt_state = cur_ff;

        // Oscillator period count shared by every consumer
        nxt_state.phase = dscs_phase_next(cur_ff.phase);

        // Boot option pin: two-stage synchroniser, caught once after reset release
        nxt_state.boot_s1 = boot_double_speed_option;
        nxt_state.boot_s2 = cur_ff.boot_s1;
        if (!cur_ff.boot_done) begin
            if (cur_ff.boot_cnt == DSCS_BOOT_WAIT) begin
                nxt_state.boot_done                  = 1'b1;
                nxt_state.speed_main[DSCS_BIT_CPU]   = cur_ff.boot_s2;
                nxt_state.cpu_fast                   = cur_ff.boot_s2;
            end else begin
                nxt_state.boot_cnt = cur_ff.boot_cnt + 2'h1;
            end
        end

        // Select bits reach the clock logic only on the divided clock rising edge
        if (cur_ff.boot_done && div2_rise) begin
            nxt_state.cpu_fast   = cur_ff.speed_main[DSCS_BIT_CPU];
            nxt_state.periph_sel = periph_sel_now;
        end

        // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero
        nxt_state.ack   = req;
        nxt_state.rdata = 8'h00;
        if (req) begin
            case (idx)
                DSCS_IDX_SPEED_MAIN: begin
                    nxt_state.rdata = cur_ff.speed_main;
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_state.speed_main = wb_dat_i[7:0];
                    end
                end
                DSCS_IDX_SPEED_SERIAL: begin
                    // Upper bits are not stored and read as zero
                    nxt_state.rdata[DSCS_BIT_SPI] = cur_ff.speed_spi;
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_state.speed_spi = wb_dat_i[DSCS_BIT_SPI];
                    end
                end
                DSCS_IDX_STATUS: begin
                    nxt_state.rdata[DSCS_ST_CPU_ACTIVE] = cur_ff.cpu_fast;
                    nxt_state.rdata[DSCS_ST_BOOT_DONE]  = cur_ff.boot_done;
                end
                default: begin
                    nxt_state.rdata = 8'h00;
                end
            endcase
        end

        // Core phase clock: every period when bypassed, every other period otherwise
        nxt_state.core_en   = cur_ff.cpu_fast || cur_ff.phase[0];
        nxt_state.mcycle_en = pulse_vec[0];
        nxt_state.periph_en = pulse_vec[DSCS_NUM_PERIPH:1];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cur_ff.speed_main <= DSCS_RST_SPEED_MAIN;
            cur_ff.speed_spi  <= DSCS_RST_SPEED_SERIAL;
            cur_ff.cpu_fast   <= 1'b0;
            cur_ff.periph_sel <= '0;
            cur_ff.phase      <= DSCS_PHASE_ZERO;
            cur_ff.boot_s1    <= 1'b0;
            cur_ff.boot_s2    <= 1'b0;
            cur_ff.boot_cnt   <= 2'h0;
            cur_ff.boot_done  <= 1'b0;
            cur_ff.ack        <= 1'b0;
            cur_ff.rdata      <= 8'h00;
            cur_ff.core_en    <= 1'b0;
            cur_ff.mcycle_en  <= 1'b0;
            cur_ff.periph_en  <= '0;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    assign wb_ack_o                = cur_ff.ack;
    assign wb_dat_o                = {24'h00_0000, cur_ff.rdata};
    assign core_phase_en           = cur_ff.core_en;
    assign machine_cycle_en        = cur_ff.mcycle_en;
    assign cpu_double_speed_active = cur_ff.cpu_fast;
    assign timer_zero_en           = cur_ff.periph_en[0];
    assign timer_one_en            = cur_ff.periph_en[1];
    assign timer_two_en            = cur_ff.periph_en[2];
    assign serial_port_en          = cur_ff.periph_en[3];
    assign counter_array_en        = cur_ff.periph_en[4];
    assign watchdog_en             = cur_ff.periph_en[5];
    assign can_en                  = cur_ff.periph_en[6];
    assign serial_peripheral_en    = cur_ff.periph_en[7];
endmodule

// ==== dscs_clock_select_props.sv ====
// Concurrent checks on the clock select outputs
`timescale 1ns/1ps
module dscs_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic core_phase_en,
    input wire logic machine_cycle_en,
    input wire logic cpu_double_speed_active,
    input wire logic timer_zero_en,
    input wire logic can_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_mc_min_gap: assert property (machine_cycle_en |=> !machine_cycle_en [*5])
        else $error("machine cycle gap below six");
    a_mc_fast_six: assert property (
        machine_cycle_en ##1 cpu_double_speed_active [*6] |-> machine_cycle_en)
        else $error("fast machine cycle not six periods");
    a_mc_std_twelve: assert property (
        machine_cycle_en && !cpu_double_speed_active
        |-> ##12 (machine_cycle_en || cpu_double_speed_active))
        else $error("standard machine cycle not twelve periods");
    a_mc_std_no_mid: assert property (
        machine_cycle_en && !cpu_double_speed_active && !$past(cpu_double_speed_active)
        ##1 !cpu_double_speed_active [*5] |=> !machine_cycle_en)
        else $error("standard machine cycle pulsed after six periods");
    a_core_fast_each: assert property (cpu_double_speed_active [*3] |-> core_phase_en)
        else $error("core phase missing in double speed");
    a_core_std_half: assert property (
        !cpu_double_speed_active [*2] ##0 core_phase_en |=> !core_phase_en)
        else $error("core phase not divided by two");
    a_periph_slow_sync: assert property (
        !cpu_double_speed_active && !$past(cpu_double_speed_active)
        && (timer_zero_en || can_en) |-> machine_cycle_en)
        else $error("peripheral fast while cpu standard");
    a_periph_min_gap: assert property (timer_zero_en |=> !timer_zero_en [*5])
        else $error("peripheral enable gap below six");
    a_reset_std_mode: assert property (
        $rose(nrst) |-> !cpu_double_speed_active && !machine_cycle_en)
        else $error("not standard mode after reset");
endmodule

bind dscs_clock_select dscs_props u_props (.clk(clk), .nrst(nrst),
    .core_phase_en(core_phase_en), .machine_cycle_en(machine_cycle_en),
    .cpu_double_speed_active(cpu_double_speed_active),
    .timer_zero_en(timer_zero_en), .can_en(can_en));

// ==== dscs_clock_select_bench.sv ====
// Self-checking bench for the double speed clock select
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module double_speed_clock_select_bench;
    import dscs_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        boot = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic        ack;
    logic        act;
    logic [9:0]  pl;
    int          bad_count = 0;
    int          compares = 0;
    localparam logic [9:0] A_MAIN = {DSCS_IDX_SPEED_MAIN, 2'b00};
    localparam logic [9:0] A_SER = {DSCS_IDX_SPEED_SERIAL, 2'b00};
    localparam logic [9:0] A_ST = {DSCS_IDX_STATUS, 2'b00};

    dscs_clock_select uut (.clk(clk), .nrst(nrst), .boot_double_speed_option(boot),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .machine_cycle_en(pl[0]),
        .core_phase_en(pl[1]), .cpu_double_speed_active(act), .timer_zero_en(pl[2]),
        .timer_one_en(pl[3]), .timer_two_en(pl[4]), .serial_port_en(pl[5]),
        .counter_array_en(pl[6]), .watchdog_en(pl[7]), .can_en(pl[8]),
        .serial_peripheral_en(pl[9]));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= {24'h00_0000, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) begin
            bad_count++;
            finish_test();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        repeat (20) @(posedge clk);
    endtask

    task automatic period(input int i, input int e, input string nm);
        int t;
        t = 0;
        while (pl[i] !== 1'b1 && t < 40) begin
            @(posedge clk);
            t++;
        end
        if (t == 40) begin
            bad_count++;
            finish_test();
        end
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pl[i] !== 1'b1 && t < 40);
        `CHK(nm, e, t)
        if (t == 40) finish_test();
    endtask

    task automatic do_reset(input logic b);
        nrst <= 1'b0;
        boot <= b;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_standard();
        wb(1'b0, A_MAIN, 8'h00);
        `CHK("main reset", 32'h0000_0000, rd)
        wb(1'b0, A_ST, 8'h00);
        `CHK("status boot", 1'b1, rd[DSCS_ST_BOOT_DONE])
        `CHK("status std", 1'b0, rd[DSCS_ST_CPU_ACTIVE])
        wb(1'b0, 10'h3fc, 8'h00);
        `CHK("unmapped", 32'h0000_0000, rd)
        period(0, 12, "machine std");
        period(1, 2, "core std");
        for (int i = 2; i < 10; i++) period(i, 12, "periph std");
    endtask

    task automatic t_double();
        wb(1'b1, A_MAIN, 8'h01);
        wb(1'b0, A_MAIN, 8'h00);
        `CHK("main readback", 32'h0000_0001, rd)
        wb(1'b0, A_ST, 8'h00);
        `CHK("status fast", 1'b1, rd[DSCS_ST_CPU_ACTIVE])
        period(0, 6, "machine fast");
        period(1, 1, "core fast");
        for (int i = 2; i < 10; i++) period(i, 6, "periph fast");
        for (int k = 1; k < 8; k++) begin
            wb(1'b1, A_MAIN, 8'h01 | (8'h01 << k));
            period(k + 1, 12, "periph set");
            period(((k + 1) % 8) + 2, 6, "periph clear");
        end
        wb(1'b1, A_SER, 8'h01);
        wb(1'b0, A_SER, 8'h00);
        `CHK("serial readback", 32'h0000_0001, rd)
        period(9, 12, "spi set");
        wb(1'b1, A_MAIN, 8'h00);
        period(0, 12, "machine back");
        period(2, 12, "periph back");
        sel <= 4'he;
        wb(1'b1, A_MAIN, 8'h01);
        sel <= 4'hf;
        wb(1'b0, A_MAIN, 8'h00);
        `CHK("sel ignored", 32'h0000_0000, rd)
        period(0, 12, "machine sel");
    endtask

    task automatic t_boot();
        do_reset(1'b1);
        wb(1'b0, A_MAIN, 8'h00);
        `CHK("boot main", 32'h0000_0001, rd)
        `CHK("boot active", 1'b1, act)
        period(0, 6, "machine boot");
        do_reset(1'b0);
        `CHK("reset std", 1'b0, act)
    endtask

    initial begin
        do_reset(1'b0);
        t_standard();
        t_double();
        t_boot();
        finish_test();
    end
endmodule
